// ### rtl/cpu_core_state.sv
// Summary of operation
// RL1: eight-bit pointer addresses latest stack entry
// RL2: push increments pointer, then writes byte
// RL3: pop reads byte, then decrements pointer
// RL4: stack may sit anywhere in RAM
// RL5: carry negative zero overflow two enables, bits 7..2
// RL6: six flag bits read/write, reset zero
// RL7: condition flags follow results; jumps test them
// RL8: each enable gates one interrupt level
// RL9: program counter is high and low bytes
// RL10: reset loads vector from 7ffe and 7fff
// RL11: low-power modes stop fetch and execute
// RL12: standby keeps oscillator and timer running
// RL13: halt stops everything including oscillator
// RL14: RAM and configuration kept through low power
// RL15: reset clears first two RAM registers only
// RL16: 256-byte RAM mapped 0000h to 00ffh
// RL17: wake on reset or enabled interrupt
`timescale 1ns/100ps
`default_nettype none
module cpu_core_state
  import cpu_state_pkg::*;
(
  input  wire logic        ref_clk,        // system clock
  input  wire logic        rst,            // async reset, high
  input  wire logic        psel,           // apb select
  input  wire logic        penable,        // apb access phase
  input  wire logic        pwrite,         // apb direction
  input  wire logic [11:0] paddr,          // apb byte address
  input  wire logic [31:0] pwdata,         // apb write data
  output logic      [31:0] prdata,         // apb read data
  output logic             pready,         // apb ready
  output logic             pslverr,        // apb error
  input  wire logic        alu_valid,      // instruction result strobe
  input  wire logic [3:0]  alu_flags,      // result c n z v
  input  wire logic [1:0]  irq_req,        // level two, level one requests
  input  wire logic [7:0]  vector_data,    // program memory read data
  output logic      [15:0] vector_addr,    // program memory address
  output logic      [15:0] next_instruction_address, // fetch address
  output logic             fetch_enable,   // cpu may fetch and execute
  output logic             osc_enable,     // oscillator run
  output logic             timer_enable,   // timer run
  output logic      [1:0]  irq_accept,     // gated interrupt levels
  output logic      [3:0]  cond_flags      // flags for conditional jumps
);
  // ****************************************
  // state
  // ****************************************
  core_state_t  state_q;
  logic [7:0]   cpu_condition_flags_q;
  logic [7:0]   stack_top_pointer_q;
  logic [7:0]   instr_addr_high_byte_q;
  logic [7:0]   instr_addr_low_byte_q;
  logic [7:0]   ram [0:255];
  logic [7:0]   pop_data_q;
  logic         init_done_q;
  logic [7:0]   init_idx_q;
  logic         level_two_irq_enable;
  logic         level_one_irq_enable;
  logic [1:0]   irq_gated;
  logic         acc_wr;
  logic [1:0]   irq_meta_q;
  logic [1:0]   irq_mid_q;
  logic [1:0]   irq_last_q;
  logic [1:0]   irq_sync_q;
  logic         in_ram;
  logic         wake;

  assign level_two_irq_enable = cpu_condition_flags_q[LEVEL_TWO_IRQ_BIT];
  assign level_one_irq_enable = cpu_condition_flags_q[LEVEL_ONE_IRQ_BIT];
  assign irq_gated = irq_sync_q & {level_two_irq_enable, level_one_irq_enable}; // RL8
  assign wake      = |irq_gated; // RL17
  assign acc_wr    = psel && penable && pwrite && pready;
  assign in_ram    = (paddr >= REG_RAM_BASE) && (paddr < (REG_RAM_BASE + 12'h400));

  // ****************************************
  // interrupt request synchroniser
  // ****************************************
  // requests come from pins: a change counts once stages two and three agree
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_meta_q <= 2'h0;
      irq_mid_q  <= 2'h0;
      irq_last_q <= 2'h0;
    end else begin
      irq_meta_q <= irq_req;
      irq_mid_q  <= irq_meta_q;
      irq_last_q <= irq_mid_q;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_sync_q <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (irq_mid_q[i] == irq_last_q[i]) irq_sync_q[i] <= irq_last_q[i];
      end
    end
  end

  // ****************************************
  // reset vector and power sequencing
  // ****************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= CORE_VEC_HIGH;
      instr_addr_high_byte_q <= 8'h00;
      instr_addr_low_byte_q <= 8'h00;
    end else begin
      unique case (state_q)
        CORE_VEC_HIGH: begin
          instr_addr_high_byte_q <= vector_data; // RL10
          state_q <= CORE_VEC_LOW;
        end
        CORE_VEC_LOW: begin
          instr_addr_low_byte_q <= vector_data; // RL10
          state_q <= CORE_RUN;
        end
        CORE_RUN: begin
          if (acc_wr && paddr == REG_INSTR_ADDR) begin
            {instr_addr_high_byte_q, instr_addr_low_byte_q} <= pwdata[15:0]; // RL9
          end else if (acc_wr && paddr == REG_POWER && pwdata[1:0] == POWER_STANDBY) begin
            state_q <= CORE_STANDBY;
          end else if (acc_wr && paddr == REG_POWER && pwdata[1:0] == POWER_HALT) begin
            state_q <= CORE_HALT;
          end
        end
        CORE_STANDBY: if (wake) state_q <= CORE_RUN; // RL17
        CORE_HALT:    if (wake) state_q <= CORE_RUN; // RL17
        default:      state_q <= CORE_VEC_HIGH;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      vector_addr <= VECTOR_HIGH;
      next_instruction_address <= 16'h0000;
      fetch_enable <= 1'b0;
      osc_enable <= 1'b1;
      timer_enable <= 1'b1;
      irq_accept <= 2'h0;
      cond_flags <= 4'h0;
    end else begin
      vector_addr <= (state_q == CORE_VEC_HIGH) ? VECTOR_LOW : VECTOR_HIGH;
      next_instruction_address <= {instr_addr_high_byte_q, instr_addr_low_byte_q}; // RL9
      fetch_enable <= (state_q == CORE_RUN) && !(acc_wr && paddr == REG_POWER && pwdata[1:0] != POWER_RUN); // RL11
      osc_enable <= (state_q != CORE_HALT); // RL12 RL13
      timer_enable <= (state_q != CORE_HALT); // RL12 RL13
      irq_accept <= irq_gated; // RL8
      cond_flags <= cpu_condition_flags_q[7:4]; // RL7
    end
  end

  // ****************************************
  // status flags
  // ****************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cpu_condition_flags_q <= FLAGS_RESET; // RL6
    end else if (acc_wr && paddr == REG_FLAGS) begin
      cpu_condition_flags_q <= pwdata[7:0] & FLAGS_WRITE_MASK; // RL5 RL6
    end else if (alu_valid && state_q == CORE_RUN) begin
      cpu_condition_flags_q[7:4] <= alu_flags; // RL7
    end
  end

  // ****************************************
  // stack and ram
  // ****************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stack_top_pointer_q <= STACK_RESET;
      pop_data_q <= 8'h00;
    end else if (acc_wr && paddr == REG_STACK) begin
      stack_top_pointer_q <= pwdata[7:0]; // RL4
    end else if (acc_wr && paddr == REG_STACK_OP && pwdata[8]) begin
      stack_top_pointer_q <= stack_top_pointer_q + 8'h01; // RL2
    end else if (acc_wr && paddr == REG_STACK_OP && pwdata[9]) begin
      pop_data_q <= ram[stack_top_pointer_q]; // RL3
      stack_top_pointer_q <= stack_top_pointer_q - 8'h01; // RL3
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      init_done_q <= 1'b0;
      init_idx_q <= 8'h00;
    end else if (!init_done_q) begin
      init_idx_q <= init_idx_q + 8'h01;
      if (init_idx_q == 8'h01) init_done_q <= 1'b1; // RL15
    end
  end

  // ram has no reset: contents survive low power and reset except r0, r1
  always_ff @(posedge ref_clk) begin
    if (!init_done_q) begin
      ram[init_idx_q] <= 8'h00; // RL15
    end else if (acc_wr && paddr == REG_STACK_OP && pwdata[8]) begin
      ram[stack_top_pointer_q + 8'h01] <= pwdata[7:0]; // RL2
    end else if (acc_wr && in_ram) begin
      ram[paddr[9:2]] <= pwdata[7:0]; // RL16 RL14
    end
  end

  // ****************************************
  // apb slave
  // ****************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable && init_done_q;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        pslverr <= !(in_ram || paddr == REG_FLAGS || paddr == REG_STACK || paddr == REG_INSTR_ADDR
                     || paddr == REG_POWER || paddr == REG_STACK_OP);
        prdata <= 32'h0000_0000;
        if (!pwrite) begin
          if (in_ram) prdata <= {24'h0, ram[paddr[9:2]]}; // RL16
          else if (paddr == REG_FLAGS) prdata <= {24'h0, cpu_condition_flags_q}; // RL5
          else if (paddr == REG_STACK) prdata <= {24'h0, stack_top_pointer_q}; // RL1
          else if (paddr == REG_INSTR_ADDR) prdata <= {16'h0, instr_addr_high_byte_q, instr_addr_low_byte_q};
          else if (paddr == REG_POWER) prdata <= {29'h0, state_q};
          else if (paddr == REG_STACK_OP) prdata <= {24'h0, pop_data_q};
        end
      end else if (!psel) begin
        pready <= 1'b0;
      end
      if (pready) pready <= 1'b0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_push_increments: assert property (@(posedge ref_clk) disable iff (rst)
    (acc_wr && paddr == REG_STACK_OP && pwdata[8]) |=> stack_top_pointer_q == $past(stack_top_pointer_q) + 8'h01)
    else $error("push did not increment pointer"); // RL2
  a_pop_decrements: assert property (@(posedge ref_clk) disable iff (rst)
    (acc_wr && paddr == REG_STACK_OP && !pwdata[8] && pwdata[9]) |=> stack_top_pointer_q == $past(stack_top_pointer_q) - 8'h01)
    else $error("pop did not decrement pointer"); // RL3
  a_flags_reserved: assert property (@(posedge ref_clk) disable iff (rst)
    cpu_condition_flags_q[1:0] == 2'b00)
    else $error("reserved flag bits set"); // RL5
  a_irq_gate_ok: assert property (@(posedge ref_clk) disable iff (rst)
    irq_accept[1] |-> $past(irq_sync_q[1] && level_two_irq_enable))
    else $error("level two passed while disabled"); // RL8
  a_low_no_fetch: assert property (@(posedge ref_clk) disable iff (rst)
    (state_q == CORE_STANDBY || state_q == CORE_HALT) |=> !fetch_enable)
    else $error("fetch during low power"); // RL11
  a_standby_osc: assert property (@(posedge ref_clk) disable iff (rst)
    $past(state_q == CORE_STANDBY) |-> osc_enable && timer_enable)
    else $error("standby stopped oscillator"); // RL12
  a_halt_stops: assert property (@(posedge ref_clk) disable iff (rst)
    $past(state_q == CORE_HALT) |-> !osc_enable && !timer_enable)
    else $error("halt left oscillator running"); // RL13
  a_vector_load: assert property (@(posedge ref_clk) disable iff (rst)
    (state_q == CORE_VEC_LOW) |=> instr_addr_low_byte_q == $past(vector_data) && state_q == CORE_RUN)
    else $error("reset vector low byte not loaded"); // RL10
  a_wake_exit: assert property (@(posedge ref_clk) disable iff (rst)
    (state_q == CORE_HALT && wake) |=> state_q == CORE_RUN)
    else $error("enabled interrupt did not wake"); // RL17

  a_flags_sw_write: assert property (@(posedge ref_clk) disable iff (rst)
    (acc_wr && paddr == REG_FLAGS) |=> cpu_condition_flags_q == ($past(pwdata[7:0]) & FLAGS_WRITE_MASK))
    else $error("flag write not taken"); // RL6
  a_flags_alu_load: assert property (@(posedge ref_clk) disable iff (rst)
    (alu_valid && state_q == CORE_RUN && !(acc_wr && paddr == REG_FLAGS)) |=> cpu_condition_flags_q[7:4] == $past(alu_flags))
    else $error("result flags not loaded"); // RL7
  a_flags_hold_low: assert property (@(posedge ref_clk) disable iff (rst)
    (state_q != CORE_RUN && !(acc_wr && paddr == REG_FLAGS)) |=> $stable(cpu_condition_flags_q))
    else $error("flags changed while stopped"); // RL11 RL14
  a_cond_mirror: assert property (@(posedge ref_clk) disable iff (rst)
    cond_flags == $past(cpu_condition_flags_q[7:4]))
    else $error("jump flags differ from status"); // RL7
  a_irq_level_one: assert property (@(posedge ref_clk) disable iff (rst)
    irq_accept[0] |-> $past(irq_sync_q[0] && level_one_irq_enable))
    else $error("level one passed while disabled"); // RL8

  a_push_writes: assert property (@(posedge ref_clk) disable iff (rst)
    (acc_wr && paddr == REG_STACK_OP && pwdata[8]) |=> ram[stack_top_pointer_q] == $past(pwdata[7:0]))
    else $error("pushed byte not at new top"); // RL2
  a_pop_data: assert property (@(posedge ref_clk) disable iff (rst)
    (acc_wr && paddr == REG_STACK_OP && !pwdata[8] && pwdata[9]) |=> pop_data_q == $past(ram[stack_top_pointer_q]))
    else $error("pop read wrong byte"); // RL3
  a_stack_load: assert property (@(posedge ref_clk) disable iff (rst)
    (acc_wr && paddr == REG_STACK) |=> stack_top_pointer_q == $past(pwdata[7:0]))
    else $error("stack pointer load lost"); // RL1 RL4
  a_ram_write_lands: assert property (@(posedge ref_clk) disable iff (rst)
    (acc_wr && in_ram) |=> ram[$past(paddr[9:2])] == $past(pwdata[7:0]))
    else $error("ram write lost"); // RL16
  a_init_clears: assert property (@(posedge ref_clk) disable iff (rst)
    !init_done_q |=> ram[$past(init_idx_q)] == 8'h00)
    else $error("working register not cleared"); // RL15
  a_init_two_only: assert property (@(posedge ref_clk) disable iff (rst)
    init_done_q |-> init_idx_q == 8'h02)
    else $error("reset cleared more than two registers"); // RL15

  a_pc_mirror: assert property (@(posedge ref_clk) disable iff (rst)
    next_instruction_address == $past({instr_addr_high_byte_q, instr_addr_low_byte_q}))
    else $error("fetch address differs from counter"); // RL9
  a_vector_high: assert property (@(posedge ref_clk) disable iff (rst)
    (state_q == CORE_VEC_HIGH) |=> instr_addr_high_byte_q == $past(vector_data))
    else $error("reset vector high byte not loaded"); // RL10
  a_vector_addr_hi: assert property (@(posedge ref_clk) disable iff (rst)
    (state_q == CORE_VEC_HIGH) |-> vector_addr == VECTOR_HIGH)
    else $error("high vector not addressed"); // RL10
  a_vector_addr_lo: assert property (@(posedge ref_clk) disable iff (rst)
    (state_q == CORE_VEC_LOW) |-> vector_addr == VECTOR_LOW)
    else $error("low vector not addressed"); // RL10
  a_low_hold_pc: assert property (@(posedge ref_clk) disable iff (rst)
    (state_q == CORE_STANDBY || state_q == CORE_HALT) |=> $stable({instr_addr_high_byte_q, instr_addr_low_byte_q}))
    else $error("counter moved in low power"); // RL11 RL14

  a_run_fetch: assert property (@(posedge ref_clk) disable iff (rst)
    $past(state_q == CORE_RUN && !(acc_wr && paddr == REG_POWER && pwdata[1:0] != POWER_RUN)) |-> fetch_enable)
    else $error("no fetch while running"); // RL11
  a_halt_no_fetch: assert property (@(posedge ref_clk) disable iff (rst)
    $past(state_q == CORE_HALT) |-> !fetch_enable)
    else $error("fetch while halted"); // RL11 RL13
  a_run_osc: assert property (@(posedge ref_clk) disable iff (rst)
    $past(state_q == CORE_RUN) |-> osc_enable && timer_enable)
    else $error("oscillator off while running"); // RL12
  a_standby_wake: assert property (@(posedge ref_clk) disable iff (rst)
    (state_q == CORE_STANDBY && wake) |=> state_q == CORE_RUN)
    else $error("enabled interrupt did not end standby"); // RL17

  a_ready_pulse: assert property (@(posedge ref_clk) disable iff (rst)
    pready |=> !pready)
    else $error("ready held past one cycle");
  a_read_flags: assert property (@(posedge ref_clk) disable iff (rst)
    (psel && !penable && !pwrite && paddr == REG_FLAGS) |=> prdata == {24'h0, $past(cpu_condition_flags_q)})
    else $error("flag read wrong"); // RL5 RL6
  a_read_stack: assert property (@(posedge ref_clk) disable iff (rst)
    (psel && !penable && !pwrite && paddr == REG_STACK) |=> prdata == {24'h0, $past(stack_top_pointer_q)})
    else $error("stack pointer read wrong"); // RL1
  a_read_popped: assert property (@(posedge ref_clk) disable iff (rst)
    (psel && !penable && !pwrite && paddr == REG_STACK_OP) |=> prdata == {24'h0, $past(pop_data_q)})
    else $error("popped byte read wrong"); // RL3
endmodule
`default_nettype wire

// ### rtl/cpu_state_pkg.sv
`default_nettype none
package cpu_state_pkg;
  // status register field positions
  localparam int FLAG_CARRY_BIT      = 7;
  localparam int FLAG_NEGATIVE_BIT   = 6;
  localparam int FLAG_ZERO_BIT       = 5;
  localparam int FLAG_OVERFLOW_BIT   = 4;
  localparam int LEVEL_TWO_IRQ_BIT   = 3;
  localparam int LEVEL_ONE_IRQ_BIT   = 2;
  localparam logic [7:0] FLAGS_WRITE_MASK = 8'hfc;
  localparam logic [7:0] FLAGS_RESET      = 8'h00;
  localparam logic [7:0] STACK_RESET      = 8'h00;
  // memory map
  localparam logic [15:0] RAM_BASE        = 16'h0000;
  localparam logic [15:0] RAM_LAST        = 16'h00ff;
  localparam logic [15:0] VECTOR_HIGH     = 16'h7ffe;
  localparam logic [15:0] VECTOR_LOW      = 16'h7fff;
  // apb register byte offsets
  localparam logic [11:0] REG_FLAGS       = 12'h000;
  localparam logic [11:0] REG_STACK       = 12'h004;
  localparam logic [11:0] REG_INSTR_ADDR  = 12'h008;
  localparam logic [11:0] REG_POWER       = 12'h00c;
  localparam logic [11:0] REG_STACK_OP    = 12'h010;
  localparam logic [11:0] REG_RAM_BASE    = 12'h400;
  // power control field codes
  localparam logic [1:0] POWER_RUN        = 2'h0;
  localparam logic [1:0] POWER_STANDBY    = 2'h1;
  localparam logic [1:0] POWER_HALT       = 2'h2;
  typedef enum logic [2:0] {
    CORE_VEC_HIGH,
    CORE_VEC_LOW,
    CORE_RUN,
    CORE_STANDBY,
    CORE_HALT
  } core_state_t;
endpackage
`default_nettype wire

// ### tb/tb_cpu_core_state.sv
`timescale 1ns/100ps
`default_nettype none
module tb_cpu_core_state;
  import cpu_state_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr, alu_valid;
  logic        fetch_enable, osc_enable, timer_enable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        er;
  logic [3:0]  alu_flags, cond_flags;
  logic [1:0]  irq_req, irq_accept;
  logic [7:0]  vector_data;
  logic [15:0] vector_addr, next_instruction_address;
  int          failures, tests_run;
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e; logic err;} row_t;
  row_t rows [8] = '{
    '{1'b1, REG_FLAGS, 32'hff, 32'h0, 1'b0}, '{1'b0, REG_FLAGS, 32'h0, 32'hfc, 1'b0},
    '{1'b1, REG_STACK, 32'h5a, 32'h0, 1'b0}, '{1'b0, REG_STACK, 32'h0, 32'h5a, 1'b0},
    '{1'b1, 12'h7fc, 32'hc3, 32'h0, 1'b0}, '{1'b0, 12'h7fc, 32'h0, 32'hc3, 1'b0},
    '{1'b1, 12'h014, 32'h1, 32'h0, 1'b1}, '{1'b0, 12'h014, 32'h0, 32'h0, 1'b1}};
  // program memory holds the reset vector
  assign vector_data = (vector_addr === VECTOR_HIGH) ? 8'h6a : 8'h5c;
  cpu_core_state i_cpu_core_state (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .alu_valid(alu_valid),
    .alu_flags(alu_flags), .irq_req(irq_req), .vector_data(vector_data), .vector_addr(vector_addr),
    .next_instruction_address(next_instruction_address), .fetch_enable(fetch_enable),
    .osc_enable(osc_enable), .timer_enable(timer_enable), .irq_accept(irq_accept), .cond_flags(cond_flags));
  // ****************************************
  // tasks
  // ****************************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 20) begin
      failures++;
      end_of_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task step(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task wfetch;
    int n;
    n = 0;
    while (fetch_enable !== 1'b1 && n < 50) begin
      step(1);
      n++;
    end
  endtask
  task pulse_alu(input logic [3:0] f);
    @(posedge ref_clk);
    alu_valid <= 1'b1;
    alu_flags <= f;
    @(posedge ref_clk);
    alu_valid <= 1'b0;
    step(2);
  endtask
  task do_reset;
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  task end_of_test;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ****************************************
  // clock, watchdog, sequence
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #200000;
    failures++;
    end_of_test();
  end
  initial begin
    {psel, penable, pwrite, alu_valid, paddr, pwdata, alu_flags, irq_req} = '0;
    failures = 0;
    tests_run = 0;
    rst = 1'b1;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    step(3);
    chk({16'h0, next_instruction_address}, 32'h6a5c);
    chk({osc_enable, timer_enable, fetch_enable}, 3'b111);
    rchk(REG_INSTR_ADDR, 32'h6a5c);
    rchk(REG_FLAGS, 32'h0);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk({rd[30:0], er}, {rows[i].e[30:0], rows[i].err});
      else chk({31'h0, er}, {31'h0, rows[i].err});
    end
    apb(1'b1, REG_RAM_BASE, 32'h11);
    apb(1'b1, 12'h408, 32'h22);
    do_reset();
    rchk(REG_RAM_BASE, 32'h0);
    rchk(12'h408, 32'h22);
    rchk(REG_INSTR_ADDR, 32'h6a5c);
    apb(1'b1, REG_STACK, 32'h7f);
    apb(1'b1, REG_STACK_OP, 32'h1a1);
    rchk(REG_STACK, 32'h80);
    rchk(12'h600, 32'ha1);
    apb(1'b1, REG_STACK_OP, 32'h200);
    rchk(REG_STACK_OP, 32'ha1);
    rchk(REG_STACK, 32'h7f);
    apb(1'b1, REG_FLAGS, 32'h08);
    pulse_alu(4'ha);
    chk(cond_flags, 4'ha);
    rchk(REG_FLAGS, 32'ha8);
    @(posedge ref_clk);
    irq_req <= 2'b11;
    step(6);
    chk(irq_accept, 2'b10);
    @(posedge ref_clk);
    irq_req <= 2'b00;
    step(6);
    apb(1'b1, REG_POWER, {30'h0, POWER_STANDBY});
    step(1);
    chk({osc_enable, timer_enable, fetch_enable}, 3'b110);
    rchk(REG_POWER, 32'h3);
    pulse_alu(4'h5);
    @(posedge ref_clk);
    irq_req <= 2'b01;
    step(4);
    chk(fetch_enable, 1'b0);
    @(posedge ref_clk);
    irq_req <= 2'b10;
    wfetch();
    chk(fetch_enable, 1'b1);
    @(posedge ref_clk);
    irq_req <= 2'b00;
    rchk(REG_FLAGS, 32'ha8);
    rchk(12'h600, 32'ha1);
    apb(1'b1, REG_POWER, {30'h0, POWER_HALT});
    step(1);
    chk({osc_enable, timer_enable, fetch_enable}, 3'b000);
    @(posedge ref_clk);
    irq_req <= 2'b10;
    wfetch();
    chk({osc_enable, fetch_enable}, 2'b11);
    @(posedge ref_clk);
    irq_req <= 2'b00;
    rchk(REG_STACK, 32'h7f);
    end_of_test();
  end
endmodule
`default_nettype wire
